// ### rtl/dtp_defines.svh
// constants for the debug and trace port start-up block
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH
// register byte offsets
`define DTP_ADR_CTRL 8'h00
`define DTP_ADR_STAT 8'h04
`define DTP_ADR_RXD 8'h08
// control fields
`define DTP_CTRL_SPRD 0
`define DTP_CTRL_PDIS_LO 8
`define DTP_CTRL_PDIS_HI 11
// status fields
`define DTP_ST_EN 0
`define DTP_ST_FULL 1
`define DTP_ST_RXAV 2
`define DTP_ST_EVTPD 3
`define DTP_ST_MCKPD 4
`define DTP_ST_MSIPU 5
// reset values
`define DTP_PDIS_RST 4'h0
`define DTP_WORD_ZERO 32'h0000_0000
// serialiser beats and data-out lane enables
`define DTP_BEATS_RED 2'h3
`define DTP_RX_FULL_CNT 4'h4
`define DTP_RX_RED_CNT 4'h8
`define DTP_MDO_RED_OE 8'h03
`define DTP_MDO_FULL_OE 8'hff
`endif

// ### rtl/dtp_fifo.sv
// trace byte fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module dtp_fifo #(
   parameter int W = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic in_valid,
   output var logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic [AW:0] cnt_d;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
         cnt_d = cnt_q + 1'b1;
      else if (pop && !push)
         cnt_d = cnt_q - 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (clk_en && push)
         mem[wr_q] <= in_data;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
         in_ready <= 1'b0;
      end
      else if (clk_en)
      begin
         if (push)
            wr_q <= AW'((wr_q + 1'b1) % DEPTH);
         if (pop)
            rd_q <= AW'((rd_q + 1'b1) % DEPTH);
         cnt_q <= cnt_d;
         // registered ready: honest, one slot of slack is never needed
         in_ready <= (cnt_d < (AW+1)'(DEPTH));
      end
   end
endmodule
`default_nettype wire

// ### rtl/dtp_pkg.sv
// shared types for the debug and trace port start-up block
package dtp_pkg;
   typedef struct packed {
      logic en;
      logic full;
   } dtp_cfg_t;
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } dtp_word_t;
   typedef enum logic {TX_IDLE, TX_SHIFT} dtp_tx_st_t;
endpackage

// ### rtl/dtp_top.sv
// debug and trace auxiliary port start-up, pulls and message path
// ---------------------------------------------------------------
// Notes on behaviour
// - the port is enabled at the tool reset rising edge only if event-in is low.
// - on small parts an enable edge while power-on reset is low is ignored.
// - data-in line 0 at the tool reset rising edge picks full or reduced width.
// - event-in high at the edge leaves the port disabled with outputs off.
// - event-in low and data-in 0 high give full width, 2 in and 8 out.
// - event-in and data-in 0 low give reduced width, 1 in and 2 out.
// - the event-in pull-down stays on until software sets its disable bit while the port is enabled.
// - pull-downs on message clock in and data-in 0 drop when reset ends.
// - start-in and data-in 1 pulls stay on until disable field bit 0 is set.
// - full width sends one byte per system clock.
// - inbound 2-bit data runs at half the system clock or slower.
// - the message clock out runs at the system clock and times the outputs.
// - reduced width drives only data-out lines 0 and 1.
// - start/end out marks the first and last transfer of each packet.
// ---------------------------------------------------------------
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.svh"
module dtp_top #(
   parameter bit SMALL_FAMILY = 1'b1,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic power_on_reset_n,
   input wire logic hard_reset_n,
   input wire logic tool_reset_n,
   input wire logic event_in_n,
   input wire logic [1:0] msg_data_in,
   input wire logic msg_clk_in,
   input wire logic msg_start_in_n,
   input wire logic pull_sel,
   input wire logic trc_valid,
   output var logic trc_ready,
   input wire logic [7:0] trc_data,
   input wire logic trc_last,
   output logic [7:0] msg_data_out,
   output logic [7:0] msg_data_oe,
   output logic msg_start_end_n,
   output logic msg_start_end_oe,
   output logic msg_clk_run,
   output logic msg_clk_oe,
   output logic [7:0] msg_in_byte,
   output logic msg_in_valid,
   output logic evt_pulldown_en,
   output logic mck_pulldown_en,
   output logic mdi0_pulldown_en,
   output logic aux_pull_en,
   output logic aux_pull_up,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o
);
   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [8:0] pin_raw;
   logic [8:0] s1_q;
   logic [8:0] s2_q;
   logic por_s, hrst_s, rsti_s, evt_s, mdi0_s, mdi1_s, msi_s, mck_s, psel_s;
   logic rsti_prev_q, mck_prev_q, rsti_rise, rsti_fall, mck_rise;

   assign pin_raw = {pull_sel, msg_clk_in, msg_start_in_n, msg_data_in,
                     event_in_n, tool_reset_n, hard_reset_n, power_on_reset_n};
   assign {psel_s, mck_s, msi_s, mdi1_s, mdi0_s, evt_s, rsti_s, hrst_s,
           por_s} = s2_q;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1_q <= '0;
         s2_q <= '0;
         rsti_prev_q <= 1'b0;
         mck_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         s1_q <= pin_raw;
         s2_q <= s1_q;
         rsti_prev_q <= rsti_s;
         mck_prev_q <= mck_s;
      end
   end

   assign rsti_rise = rsti_s && !rsti_prev_q;
   assign rsti_fall = !rsti_s && rsti_prev_q;
   assign mck_rise = mck_s && !mck_prev_q;

   // ------------------------------------------------------------
   // enable and width capture
   // ------------------------------------------------------------
   dtp_pkg::dtp_cfg_t cfg_q;
   logic accept;

   // synced levels share the edge's delay, so the 4-clock setup holds
   assign accept = rsti_rise && (por_s || !SMALL_FAMILY);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg_q <= '0;
      else if (clk_en)
      begin
         if (accept)
         begin
            cfg_q.en <= !evt_s;
            cfg_q.full <= !evt_s && mdi0_s;
         end
         else if (!por_s || rsti_fall)
            cfg_q <= '0;
      end
   end

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   logic sprd_q;
   logic [3:0] pdis_q;
   logic rx_av_q;
   logic bus_req, rd_rxd;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign rd_rxd = bus_req && !wb_we_i && (wb_adr_i == `DTP_ADR_RXD);

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= `DTP_WORD_ZERO;
         sprd_q <= 1'b0;
         pdis_q <= `DTP_PDIS_RST;
      end
      else if (clk_en)
      begin
         wb_ack_o <= bus_req;
         wb_dat_o <= `DTP_WORD_ZERO;
         if (bus_req && wb_we_i && wb_adr_i == `DTP_ADR_CTRL)
         begin
            if (wb_sel_i[0])
               sprd_q <= wb_dat_i[`DTP_CTRL_SPRD];
            if (wb_sel_i[1])
               pdis_q <= wb_dat_i[`DTP_CTRL_PDIS_HI:`DTP_CTRL_PDIS_LO];
         end
         if (bus_req && !wb_we_i)
         begin
            case (wb_adr_i)
               `DTP_ADR_CTRL:
               begin
                  wb_dat_o[`DTP_CTRL_SPRD] <= sprd_q;
                  wb_dat_o[`DTP_CTRL_PDIS_HI:`DTP_CTRL_PDIS_LO] <= pdis_q;
               end
               `DTP_ADR_STAT:
               begin
                  wb_dat_o[`DTP_ST_EN] <= cfg_q.en;
                  wb_dat_o[`DTP_ST_FULL] <= cfg_q.full;
                  wb_dat_o[`DTP_ST_RXAV] <= rx_av_q;
                  wb_dat_o[`DTP_ST_EVTPD] <= evt_pulldown_en;
                  wb_dat_o[`DTP_ST_MCKPD] <= mck_pulldown_en;
                  wb_dat_o[`DTP_ST_MSIPU] <= aux_pull_en;
               end
               `DTP_ADR_RXD:
                  wb_dat_o[7:0] <= msg_in_byte;
               default:
                  wb_dat_o <= `DTP_WORD_ZERO;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // pull control
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         evt_pulldown_en <= 1'b1;
         mck_pulldown_en <= 1'b1;
         mdi0_pulldown_en <= 1'b1;
         aux_pull_en <= 1'b1;
         aux_pull_up <= 1'b0;
      end
      else if (clk_en)
      begin
         evt_pulldown_en <= !(cfg_q.en && sprd_q);
         if (!por_s)
         begin
            mck_pulldown_en <= 1'b1;
            mdi0_pulldown_en <= 1'b1;
         end
         else if (hrst_s)
         begin
            mck_pulldown_en <= 1'b0;
            mdi0_pulldown_en <= 1'b0;
         end
         aux_pull_en <= !pdis_q[0];
         aux_pull_up <= psel_s;
      end
   end

   // ------------------------------------------------------------
   // outbound trace path
   // ------------------------------------------------------------
   dtp_pkg::dtp_word_t f_word;
   dtp_pkg::dtp_tx_st_t st_q;
   logic f_valid, pop, first_q, last_q;
   logic [5:0] sh_q;
   logic [1:0] beat_q;

   // a disabled port stops draining, so the source sees back-pressure
   assign pop = cfg_q.en && f_valid && (st_q == dtp_pkg::TX_IDLE);

   dtp_fifo #(
      .W(9),
      .DEPTH(FIFO_DEPTH)
   ) dtp_fifo_inst (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(trc_valid),
      .in_ready(trc_ready),
      .in_data({trc_last, trc_data}),
      .out_valid(f_valid),
      .out_ready(pop),
      .out_data(f_word)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= dtp_pkg::TX_IDLE;
         sh_q <= '0;
         beat_q <= '0;
         first_q <= 1'b1;
         last_q <= 1'b0;
         msg_data_out <= '0;
         msg_start_end_n <= 1'b1;
      end
      else if (clk_en)
      begin
         msg_start_end_n <= 1'b1;
         msg_data_out <= '0;
         case (st_q)
            dtp_pkg::TX_IDLE:
            begin
               if (pop && cfg_q.full)
               begin
                  msg_data_out <= f_word.data;
                  msg_start_end_n <= !(first_q || f_word.last);
                  first_q <= f_word.last;
               end
               else if (pop)
               begin
                  msg_data_out <= {6'h00, f_word.data[1:0]};
                  msg_start_end_n <= !first_q;
                  sh_q <= f_word.data[7:2];
                  last_q <= f_word.last;
                  first_q <= 1'b0;
                  beat_q <= `DTP_BEATS_RED;
                  st_q <= dtp_pkg::TX_SHIFT;
               end
            end
            dtp_pkg::TX_SHIFT:
            begin
               msg_data_out <= {6'h00, sh_q[1:0]};
               sh_q <= {2'h0, sh_q[5:2]};
               beat_q <= beat_q - 1'b1;
               if (beat_q == 2'h1)
               begin
                  msg_start_end_n <= !last_q;
                  first_q <= last_q;
                  st_q <= dtp_pkg::TX_IDLE;
               end
               if (!cfg_q.en)
                  st_q <= dtp_pkg::TX_IDLE;
            end
            default:
               st_q <= dtp_pkg::TX_IDLE;
         endcase
      end
   end

   // output enables: tri-state while disabled, 2 lanes in reduced form
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         msg_data_oe <= '0;
         msg_start_end_oe <= 1'b0;
         msg_clk_oe <= 1'b0;
         msg_clk_run <= 1'b0;
      end
      else if (clk_en)
      begin
         msg_data_oe <= !cfg_q.en ? 8'h00 :
            (cfg_q.full ? `DTP_MDO_FULL_OE : `DTP_MDO_RED_OE);
         msg_start_end_oe <= cfg_q.en;
         msg_clk_oe <= cfg_q.en;
         // pad gates clk itself: the message clock equals the system clock
         msg_clk_run <= cfg_q.en;
      end
   end

   // ------------------------------------------------------------
   // inbound messages
   // ------------------------------------------------------------
   logic [7:0] in_sh_q;
   logic [3:0] in_cnt_q;
   logic [3:0] in_need;

   assign in_need = cfg_q.full ? `DTP_RX_FULL_CNT : `DTP_RX_RED_CNT;

   // link clock is sampled; it must stay well under half of clk
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         in_sh_q <= '0;
         in_cnt_q <= '0;
         msg_in_byte <= '0;
         msg_in_valid <= 1'b0;
         rx_av_q <= 1'b0;
      end
      else if (clk_en)
      begin
         msg_in_valid <= 1'b0;
         if (rd_rxd)
            rx_av_q <= 1'b0;
         if (cfg_q.en && mck_rise)
         begin
            if (cfg_q.full)
               in_sh_q <= {mdi1_s, mdi0_s, in_sh_q[7:2]};
            else
               in_sh_q <= {mdi0_s, in_sh_q[7:1]};
            if (msi_s && in_cnt_q == in_need - 1'b1)
            begin
               in_cnt_q <= '0;
               msg_in_byte <= cfg_q.full ? {mdi1_s, mdi0_s, in_sh_q[7:2]} :
                  {mdi0_s, in_sh_q[7:1]};
               msg_in_valid <= 1'b1;
               rx_av_q <= 1'b1;
            end
            else if (!msi_s)
               in_cnt_q <= 4'h1;
            else
               in_cnt_q <= in_cnt_q + 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_accept;
      clk_en && accept;
   endsequence
   sequence s_early;
      clk_en && rsti_rise && !por_s;
   endsequence

   property p_evt_blocks;
      s_accept ##0 evt_s |=> !cfg_q.en;
   endproperty
   a_evt_blocks: assert property (p_evt_blocks)
      else $error("port enabled with event-in high");
   property p_por_ignore;
      s_early ##0 SMALL_FAMILY |=> !cfg_q.en;
   endproperty
   a_por_ignore: assert property (p_por_ignore)
      else $error("enable edge during power-on reset taken");
   property p_width;
      s_accept ##0 !evt_s |=> cfg_q.en && cfg_q.full == $past(mdi0_s);
   endproperty
   a_width: assert property (p_width)
      else $error("width not taken from data-in 0");
   property p_tristate;
      clk_en && !cfg_q.en |=> msg_data_oe == 8'h00 && !msg_start_end_oe;
   endproperty
   a_tristate: assert property (p_tristate)
      else $error("outputs driven while disabled");
   property p_reduced;
      clk_en && cfg_q.en && !cfg_q.full |=> msg_data_oe == `DTP_MDO_RED_OE;
   endproperty
   a_reduced: assert property (p_reduced)
      else $error("reduced form drives lanes above 1");
   property p_hold;
      clk_en && por_s && !rsti_rise && !rsti_fall |=> $stable(cfg_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("setting changed without reset");
   property p_rate;
      clk_en && pop && cfg_q.full |=> msg_data_out == $past(f_word.data);
   endproperty
   a_rate: assert property (p_rate)
      else $error("full-width byte not sent next clock");
   property p_mark;
      clk_en && pop && first_q |=> !msg_start_end_n;
   endproperty
   a_mark: assert property (p_mark)
      else $error("packet start not marked");
   property p_pull_rel;
      clk_en && por_s && hrst_s |=> !mck_pulldown_en && !mdi0_pulldown_en;
   endproperty
   a_pull_rel: assert property (p_pull_rel)
      else $error("clock-in pull-down kept after reset");
   property p_aux_pull;
      clk_en && pdis_q[0] |=> !aux_pull_en;
   endproperty
   a_aux_pull: assert property (p_aux_pull)
      else $error("aux pull kept after disable");
endmodule
`default_nettype wire

// ### verif/dtp_tool_model.sv
// behavioural debug tool on the far side of the auxiliary port
`timescale 1ns/1ps
`default_nettype none
module dtp_tool_model (
   input wire logic clk,
   output logic tool_reset_n,
   output logic hard_reset_n,
   output logic event_in_n,
   output logic [1:0] msg_data_in,
   output logic msg_clk_in,
   output logic msg_start_in_n
);
   initial
   begin
      tool_reset_n = 1'b0;
      hard_reset_n = 1'b0;
      event_in_n = 1'b1;
      msg_data_in = 2'h0;
      msg_clk_in = 1'b0;
      msg_start_in_n = 1'b1;
   end
   // pins flip after the hold so a stale re-sample would show
   task automatic configure(input logic evt_n, input logic mdi0);
      @(posedge clk);
      tool_reset_n <= 1'b0;
      hard_reset_n <= 1'b0;
      event_in_n <= evt_n;
      msg_data_in[0] <= mdi0;
      repeat (6) @(posedge clk);
      tool_reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      hard_reset_n <= 1'b1;
      event_in_n <= ~evt_n;
      msg_data_in[0] <= ~mdi0;
   endtask
   // link clock stands still outside a frame
   task automatic send_byte(input logic [7:0] b, input logic full);
      int i;
      // step off the clk edge so no pin change of a 4-beat frame races the synchroniser
      #2;
      for (i = 0; i < (full ? 4 : 8); i++)
      begin
         msg_start_in_n = (i != 0);
         msg_data_in = full ? b[2*i +: 2] : {~msg_data_in[1], b[i]};
         #62.5 msg_clk_in = 1'b1;
         #62.5 msg_clk_in = 1'b0;
      end
      msg_start_in_n = 1'b1;
      msg_data_in = ~msg_data_in;
   endtask
endmodule
`default_nettype wire

// ### verif/test_dtp_top.sv
// self-checking bench for the trace port start-up block
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.svh"
module test_dtp_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic power_on_reset_n = 1'b0;
   logic pull_sel = 1'b1;
   logic trc_valid = 1'b0;
   logic trc_last = 1'b0;
   logic [7:0] trc_data = 8'h00;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_we_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic tool_reset_n, hard_reset_n, event_in_n, msg_clk_in, msg_start_in_n;
   logic [1:0] msg_data_in;
   logic trc_ready, msg_start_end_n, msg_start_end_oe, msg_clk_run;
   logic msg_clk_oe, msg_in_valid, wb_ack_o, aux_pull_en, aux_pull_up;
   logic evt_pulldown_en, mck_pulldown_en, mdi0_pulldown_en;
   logic [7:0] msg_data_out, msg_data_oe, msg_in_byte;
   logic [31:0] wb_dat_o;
   logic [31:0] rd;
   logic [7:0] outq[$];
   logic [7:0] rx_byte = 8'h00;
   logic rx_seen = 1'b0;
   logic took;
   int fail_count = 0;
   int num_checks = 0;
   int cnt;

   always #4 clk = ~clk;

   dtp_tool_model dtp_tool_model_inst (.clk(clk), .tool_reset_n(tool_reset_n),
      .hard_reset_n(hard_reset_n), .event_in_n(event_in_n),
      .msg_data_in(msg_data_in), .msg_clk_in(msg_clk_in),
      .msg_start_in_n(msg_start_in_n));

   dtp_top dtp_top_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
      .power_on_reset_n(power_on_reset_n), .hard_reset_n(hard_reset_n),
      .tool_reset_n(tool_reset_n), .event_in_n(event_in_n),
      .msg_data_in(msg_data_in), .msg_clk_in(msg_clk_in),
      .msg_start_in_n(msg_start_in_n), .pull_sel(pull_sel),
      .trc_valid(trc_valid), .trc_ready(trc_ready), .trc_data(trc_data),
      .trc_last(trc_last), .msg_data_out(msg_data_out),
      .msg_data_oe(msg_data_oe), .msg_start_end_n(msg_start_end_n),
      .msg_start_end_oe(msg_start_end_oe), .msg_clk_run(msg_clk_run),
      .msg_clk_oe(msg_clk_oe), .msg_in_byte(msg_in_byte),
      .msg_in_valid(msg_in_valid), .evt_pulldown_en(evt_pulldown_en),
      .mck_pulldown_en(mck_pulldown_en), .mdi0_pulldown_en(mdi0_pulldown_en),
      .aux_pull_en(aux_pull_en), .aux_pull_up(aux_pull_up),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

   // marked beats and inbound pulses are one cycle wide, so catch them here
   always @(posedge clk)
   begin
      if (msg_start_end_oe === 1'b1 && msg_start_end_n === 1'b0)
         outq.push_back(msg_data_out);
      if (msg_in_valid === 1'b1)
      begin
         rx_seen = 1'b1;
         rx_byte = msg_in_byte;
      end
   end

   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic hang;
      fail_count++;
      $display("BAD %0t wait ran out", $time);
      stop_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      @(posedge clk);
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_sel_i <= 4'hf;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 40);
      if (n >= 40)
         hang();
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   // valid stays up between calls; caller lowers it after the last byte
   task automatic push(input logic [7:0] b, input logic l);
      int n;
      trc_valid <= 1'b1;
      trc_data <= b;
      trc_last <= l;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (trc_ready !== 1'b1 && n < 20);
      took = (trc_ready === 1'b1);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk);
      hang();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      dtp_tool_model_inst.configure(1'b0, 1'b1);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[1:0]), 32'h0);
      chk(32'(mck_pulldown_en), 32'h1);
      power_on_reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[1:0]), 32'h0);
      dtp_tool_model_inst.configure(1'b1, 1'b1);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[1:0]), 32'h0);
      chk(32'({msg_data_oe, msg_clk_oe, msg_start_end_oe}), 32'h0);
      chk(32'({mck_pulldown_en, mdi0_pulldown_en}), 32'h0);
      cnt = 0;
      for (int i = 0; i < 17; i++)
      begin
         push(8'(i), i == 15);
         cnt += int'(took);
      end
      trc_valid <= 1'b0;
      chk(32'(cnt), 32'd16);
      $display("test disabled done");
      dtp_tool_model_inst.configure(1'b0, 1'b1);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[1:0]), 32'h3);
      chk(32'(msg_data_oe), 32'hff);
      chk(32'({msg_clk_run, msg_clk_oe}), 32'h3);
      repeat (30) @(posedge clk);
      chk(32'(outq.size()), 32'd2);
      chk(32'(outq[1]), 32'h0f);
      outq.delete();
      push(8'ha5, 1'b0);
      push(8'h3c, 1'b1);
      trc_valid <= 1'b0;
      repeat (10) @(posedge clk);
      chk(32'(outq.size()), 32'd2);
      chk(32'({outq[0], outq[1]}), 32'ha53c);
      rx_seen = 1'b0;
      dtp_tool_model_inst.send_byte(8'h96, 1'b1);
      repeat (4) @(posedge clk);
      chk(32'({rx_seen, rx_byte}), 32'h196);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[2]), 32'h1);
      wb(`DTP_ADR_RXD, 1'b0, 32'h0);
      chk(rd, 32'h96);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[2]), 32'h0);
      chk(32'({evt_pulldown_en, aux_pull_en, aux_pull_up}), 32'h7);
      wb(`DTP_ADR_CTRL, 1'b1, 32'h0000_0001);
      chk(32'({evt_pulldown_en, aux_pull_en}), 32'h1);
      wb(`DTP_ADR_CTRL, 1'b1, 32'h0000_0101);
      chk(32'(aux_pull_en), 32'h0);
      wb(8'h10, 1'b1, 32'hffff_ffff);
      wb(8'h0c, 1'b0, 32'h0);
      chk(rd, 32'h0);
      wb(`DTP_ADR_CTRL, 1'b0, 32'h0);
      chk(rd, 32'h0000_0101);
      $display("test full width done");
      dtp_tool_model_inst.configure(1'b0, 1'b0);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[1:0]), 32'h1);
      chk(32'(msg_data_oe), 32'h03);
      outq.delete();
      push(8'hc6, 1'b1);
      trc_valid <= 1'b0;
      repeat (12) @(posedge clk);
      chk(32'(outq.size()), 32'd2);
      chk(32'({outq[0][1:0], outq[1][1:0]}), 32'hb);
      rx_seen = 1'b0;
      dtp_tool_model_inst.send_byte(8'h5a, 1'b0);
      repeat (4) @(posedge clk);
      chk(32'({rx_seen, rx_byte}), 32'h15a);
      // a tool reset edge while frozen must leave the setting alone
      clk_en <= 1'b0;
      dtp_tool_model_inst.configure(1'b1, 1'b1);
      clk_en <= 1'b1;
      repeat (4) @(posedge clk);
      wb(`DTP_ADR_STAT, 1'b0, 32'h0);
      chk(32'(rd[1:0]), 32'h1);
      $display("test reduced width done");
      stop_test();
   end
endmodule
`default_nettype wire
